// *** rtl/pml_host.v ***
// Functional notes
// - Host programs the password before the password method flag.
// - Host writes reserved lock bits as 1; fields may be written separately.
// - Unlock supplies all 4 password words; only exact match unlocks.
// - Unlocks at most once per 100 us plus 20 us; host polls first.
`timescale 1ns/1ps
`include "pml_defs.vh"
`default_nettype none

module pml_host #(
	parameter [13:0] GAP_CYC = `PML_GAP_CYC,
	parameter [19:0] TMO_CYC = `PML_TMO_CYC
) (
	// Clock and reset
	input  wire        MCLK,
	input  wire        ARST_N,
	// User orders
	input  wire        START,
	input  wire [2:0]  OP,
	input  wire [15:0] LOCK_WORD,
	input  wire [63:0] PASSWORD,
	input  wire [1:0]  PW_INDEX,
	// User results
	output wire        BUSY,
	output reg         DONE,
	output reg         FAIL,
	output reg         REFUSED,
	output reg  [15:0] STATUS,
	output wire        PW_READY,
	output reg         METHOD_PW,
	output reg         METHOD_PS,
	// Flash bus
	output reg  [23:0] ADDR,
	output reg  [15:0] DQ_O,
	output reg         DQ_OE_N,
	input  wire [15:0] DQ_I,
	output reg         CE_N,
	output reg         OE_N,
	output reg         WE_N,
	input  wire        RDY
);

	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_WR    = 3'h1;
	localparam [2:0] S_BUSYW = 3'h2;
	localparam [2:0] S_RD    = 3'h3;
	localparam [2:0] S_END   = 3'h4;

	localparam [7:0]  WP_CYC   = `PML_WP_CYC;
	localparam [7:0]  WR_CYC   = `PML_WR_CYC;
	localparam [7:0]  RD_CYC   = `PML_RD_CYC;
	localparam [7:0]  BUSY_CYC = `PML_BUSY_CYC;

	reg  [2:0]  state;
	reg  [2:0]  op;
	reg  [3:0]  idx;
	reg  [7:0]  cnt;
	reg  [19:0] tmo;
	reg  [13:0] gap;
	reg         stat;
	reg         last;
	reg         tmo_hit;
	reg  [15:0] lw;
	reg  [63:0] pw;
	reg  [1:0]  pi;
	reg  [3:0]  pw_mask;
	reg  [15:0] dq_m;
	reg  [15:0] dq_s;
	reg         rdy_m;
	reg         rdy_s;
	wire [40:0] step;
	wire [15:0] lw_in;
	wire        refuse;

	// Step table: {last, address, data} for each bus write of an operation
	function [40:0] seq_step;
		input [2:0]  f_op;
		input [3:0]  f_idx;
		input [15:0] f_lw;
		input [63:0] f_pw;
		input [1:0]  f_pi;
		reg   [23:0] pa;
		begin
			pa = {22'h000000, f_pi};
			seq_step = {1'b1, `PML_A_BASE, `PML_D_EXIT2};
			if (f_op == `PML_OP_EXIT)
			begin
				if (f_idx == 4'h0)
					seq_step = {1'b0, `PML_A_BASE, `PML_D_EXIT1};
			end
			else if (f_idx == 4'h0)
				seq_step = {1'b0, `PML_A_UNLK1, `PML_D_UNLK1};
			else if (f_idx == 4'h1)
				seq_step = {1'b0, `PML_A_UNLK2, `PML_D_UNLK2};
			else
			begin
				case (f_op)
					`PML_OP_LOCK:
						case (f_idx)
							4'h2: seq_step = {1'b0, `PML_A_UNLK1, `PML_D_LOCK_ASO};
							4'h3: seq_step = {1'b0, `PML_A_BASE, `PML_D_PROG};
							default: seq_step = {1'b1, `PML_A_BASE, f_lw};
						endcase
					`PML_OP_PWPROG:
						case (f_idx)
							4'h2: seq_step = {1'b0, `PML_A_UNLK1, `PML_D_PW_ASO};
							4'h3: seq_step = {1'b0, pa, `PML_D_PROG};
							default: seq_step = {1'b1, pa, f_pw[{f_pi, 4'h0} +: 16]};
						endcase
					`PML_OP_UNLOCK:
						case (f_idx)
							4'h2: seq_step = {1'b0, `PML_A_UNLK1, `PML_D_PW_ASO};
							4'h3: seq_step = {1'b0, `PML_A_BASE, `PML_D_PW_UNLOCK};
							4'h4: seq_step = {1'b0, `PML_A_BASE, `PML_D_PW_COUNT};
							4'h5: seq_step = {1'b0, 24'h000000, f_pw[15:0]};
							4'h6: seq_step = {1'b0, 24'h000001, f_pw[31:16]};
							4'h7: seq_step = {1'b0, 24'h000002, f_pw[47:32]};
							4'h8: seq_step = {1'b0, 24'h000003, f_pw[63:48]};
							default: seq_step = {1'b1, `PML_A_BASE, `PML_D_PW_COMMIT};
						endcase
					default:
						case (f_idx)
							4'h2: seq_step = {1'b0, `PML_A_UNLK1, `PML_D_GUARD_ASO};
							4'h3: seq_step = {1'b0, `PML_A_BASE, `PML_D_PROG};
							default: seq_step = {1'b1, `PML_A_BASE, 16'h0000};
						endcase
				endcase
			end
		end
	endfunction

	assign step     = seq_step(op, idx, lw, pw, pi);
	assign lw_in    = LOCK_WORD | `PML_LW_RSV_MASK;
	assign BUSY     = (state != S_IDLE);
	assign PW_READY = (pw_mask == 4'hf);

	// Orders the host must not send
	assign refuse = (OP > `PML_OP_EXIT)
		| ((OP == `PML_OP_UNLOCK) & (gap != 14'h0000))
		| ((OP == `PML_OP_LOCK) & ~LOCK_WORD[`PML_LW_PERSIST] & ~LOCK_WORD[`PML_LW_PASSWD])
		| ((OP == `PML_OP_LOCK) & ~LOCK_WORD[`PML_LW_PASSWD] & (~PW_READY | METHOD_PS))
		| ((OP == `PML_OP_LOCK) & ~LOCK_WORD[`PML_LW_PERSIST] & METHOD_PW)
		| ((OP == `PML_OP_PWPROG) & METHOD_PW);

	// Pin synchronisers
	always @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			dq_m  <= 16'h0000;
			dq_s  <= 16'h0000;
			rdy_m <= 1'b0;
			rdy_s <= 1'b0;
		end
		else
		begin
			dq_m  <= DQ_I;
			dq_s  <= dq_m;
			rdy_m <= RDY;
			rdy_s <= rdy_m;
		end
	end

	// Sequencer and bus cycles
	always @(posedge MCLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			state     <= S_IDLE;
			op        <= 3'h0;
			idx       <= 4'h0;
			cnt       <= 8'h00;
			tmo       <= 20'h00000;
			gap       <= 14'h0000;
			stat      <= 1'b0;
			last      <= 1'b0;
			tmo_hit   <= 1'b0;
			lw        <= 16'hffff;
			pw        <= 64'h0000000000000000;
			pi        <= 2'h0;
			pw_mask   <= 4'h0;
			DONE      <= 1'b0;
			FAIL      <= 1'b0;
			REFUSED   <= 1'b0;
			STATUS    <= 16'h0000;
			METHOD_PW <= 1'b0;
			METHOD_PS <= 1'b0;
			ADDR      <= 24'h000000;
			DQ_O      <= 16'h0000;
			DQ_OE_N   <= 1'b1;
			CE_N      <= 1'b1;
			OE_N      <= 1'b1;
			WE_N      <= 1'b1;
		end
		else
		begin
			DONE    <= 1'b0;
			REFUSED <= 1'b0;
			if (gap != 14'h0000)
				gap <= gap - 14'h0001;
			case (state)
				S_IDLE:
				begin
					if (START && refuse)
						REFUSED <= 1'b1;
					else if (START)
					begin
						op      <= OP;
						lw      <= lw_in;
						pw      <= PASSWORD;
						pi      <= PW_INDEX;
						idx     <= 4'h0;
						stat    <= 1'b0;
						tmo_hit <= 1'b0;
						state   <= S_END;
					end
				end
				S_END:
				begin
					// Load the current step onto the bus
					ADDR    <= stat ? `PML_A_UNLK1 : step[39:16];
					DQ_O    <= stat ? `PML_D_STAT_RD : step[15:0];
					last    <= stat | step[40];
					DQ_OE_N <= 1'b0;
					CE_N    <= 1'b0;
					cnt     <= 8'h00;
					state   <= S_WR;
				end
				S_WR:
				begin
					cnt <= cnt + 8'h01;
					if (cnt == 8'h00)
						WE_N <= 1'b0;
					if (cnt == WP_CYC)
						WE_N <= 1'b1;
					if (cnt == WR_CYC)
					begin
						if (!last)
						begin
							idx   <= idx + 4'h1;
							state <= S_END;
						end
						else if (stat)
						begin
							DQ_OE_N <= 1'b1;
							OE_N    <= 1'b0;
							ADDR    <= `PML_A_BASE;
							cnt     <= 8'h00;
							state   <= S_RD;
						end
						else
						begin
							DQ_OE_N <= 1'b1;
							CE_N    <= 1'b1;
							cnt     <= 8'h00;
							tmo     <= 20'h00000;
							state   <= S_BUSYW;
						end
					end
				end
				S_BUSYW:
				begin
					// let the ready pin fall, then wait for it to rise
					tmo <= tmo + 20'h00001;
					if (cnt != BUSY_CYC)
						cnt <= cnt + 8'h01;
					else if (rdy_s || tmo >= TMO_CYC)
					begin
						tmo_hit <= ~rdy_s;
						stat    <= 1'b1;
						state   <= S_END;
					end
				end
				S_RD:
				begin
					cnt <= cnt + 8'h01;
					if (cnt == RD_CYC)
					begin
						OE_N <= 1'b1;
						CE_N <= 1'b1;
						STATUS <= dq_s;
						cnt  <= 8'h00;
						if (!dq_s[`PML_ST_READY] && !tmo_hit && tmo < TMO_CYC)
						begin
							stat  <= 1'b0;
							state <= S_BUSYW;
						end
						else
						begin
							// failure bits end the operation unchanged
							FAIL  <= tmo_hit | dq_s[`PML_ST_PFAIL] | ~dq_s[`PML_ST_READY];
							DONE  <= 1'b1;
							state <= S_IDLE;
							if (op == `PML_OP_UNLOCK)
								gap <= GAP_CYC;
							if (!tmo_hit && !dq_s[`PML_ST_PFAIL] && dq_s[`PML_ST_READY])
							begin
								if (op == `PML_OP_LOCK && !lw[`PML_LW_PASSWD])
									METHOD_PW <= 1'b1;
								if (op == `PML_OP_LOCK && !lw[`PML_LW_PERSIST])
									METHOD_PS <= 1'b1;
								if (op == `PML_OP_PWPROG)
									pw_mask[pi] <= 1'b1;
							end
						end
					end
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end

endmodule

`default_nettype wire

// *** rtl/pml_defs.vh ***
`ifndef PML_DEFS_VH
`define PML_DEFS_VH

// Operations accepted on the user port
`define PML_OP_LOCK        3'h0
`define PML_OP_PWPROG      3'h1
`define PML_OP_UNLOCK      3'h2
`define PML_OP_GCLR        3'h3
`define PML_OP_EXIT        3'h4

// Lock word field positions
`define PML_LW_FACTORY     0
`define PML_LW_PERSIST     1
`define PML_LW_PASSWD      2
`define PML_LW_CUSTOMER    6
`define PML_LW_RSV_MASK    16'hffb8

// Command addresses and codes
`define PML_A_UNLK1        24'h000555
`define PML_A_UNLK2        24'h0002aa
`define PML_A_BASE         24'h000000
`define PML_D_UNLK1        16'h00aa
`define PML_D_UNLK2        16'h0055
`define PML_D_LOCK_ASO     16'h0040
`define PML_D_PW_ASO       16'h0060
`define PML_D_GUARD_ASO    16'h0050
`define PML_D_PROG         16'h00a0
`define PML_D_PW_UNLOCK    16'h0025
`define PML_D_PW_COUNT     16'h0003
`define PML_D_PW_COMMIT    16'h0029
`define PML_D_EXIT1        16'h0090
`define PML_D_EXIT2        16'h0000
`define PML_D_STAT_RD      16'h0070

// Status word bit positions
`define PML_ST_READY       7
`define PML_ST_PFAIL       4

// Bus timing in ns, and cycle counts at 10 ns
`define PML_CLK_NS         10
`define PML_T_WP_NS        35
`define PML_T_WPH_NS       30
`define PML_T_ACC_NS       100
`define PML_T_BUSY_NS      80
`define PML_WP_CYC         ((`PML_T_WP_NS + `PML_CLK_NS - 1) / `PML_CLK_NS)
`define PML_WR_CYC         (`PML_WP_CYC + (`PML_T_WPH_NS + `PML_CLK_NS - 1) / `PML_CLK_NS)
`define PML_RD_CYC         ((`PML_T_ACC_NS + `PML_CLK_NS - 1) / `PML_CLK_NS + 2)
`define PML_BUSY_CYC       ((`PML_T_BUSY_NS + `PML_CLK_NS - 1) / `PML_CLK_NS + 2)

// Unlock spacing: 100 us nominal plus 20 us tolerance
`define PML_T_GAP_US       100
`define PML_T_GAPTOL_US    20
`define PML_GAP_CYC        ((`PML_T_GAP_US + `PML_T_GAPTOL_US) * 1000 / `PML_CLK_NS)

// Ready wait timeout
`define PML_T_TMO_US       5000
`define PML_TMO_CYC        (`PML_T_TMO_US * 1000 / `PML_CLK_NS)

`endif

// *** test/pml_host_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module pml_host_props #(
	parameter [13:0] GAP_CYC = 14'h14,
	parameter [19:0] TMO_CYC = 20'h7d0
) (
	// Clock, reset and user port
	input wire logic        MCLK, ARST_N, START, BUSY, DONE, REFUSED, PW_READY, METHOD_PW,
	input wire logic [2:0]  OP,
	input wire logic [15:0] LOCK_WORD
);
	wire         take = START && !BUSY;
	logic [2:0]  op_q;
	logic [13:0] since_ul;
	// Cycles since the last finished unlock
	always @(posedge MCLK or negedge ARST_N)
		if (!ARST_N)
		begin
			op_q     <= 3'h0;
			since_ul <= GAP_CYC;
		end
		else
		begin
			if (take)
				op_q <= OP;
			if (DONE && op_q == 3'h2)
				since_ul <= 14'h0;
			else if (since_ul < GAP_CYC)
				since_ul <= since_ul + 14'h1;
		end
	default clocking @(posedge MCLK); endclocking
	default disable iff (!ARST_N);
	AST_BOTH_METHODS: assert property (take && OP == 3'h0 && LOCK_WORD[2:1] == 2'h0 |=> REFUSED)
		else $error("dual method lock not refused");
	AST_PW_FIRST: assert property (take && OP == 3'h0 && !LOCK_WORD[2] && !PW_READY |=> REFUSED)
		else $error("password method before password");
	AST_PW_READY: assert property ($rose(METHOD_PW) |-> PW_READY)
		else $error("password method without password");
	AST_PS_AFTER_PW: assert property (take && OP == 3'h0 && !LOCK_WORD[1] && METHOD_PW |=> REFUSED)
		else $error("persistent lock after password method");
	AST_PW_REGION: assert property (take && OP == 3'h1 && METHOD_PW |=> REFUSED)
		else $error("password program after method lock");
	AST_UNLOCK_GAP: assert property (take && OP == 3'h2 && since_ul < 14'ha |=> REFUSED)
		else $error("unlock too soon");
endmodule
bind pml_host pml_host_props #(.GAP_CYC(GAP_CYC), .TMO_CYC(TMO_CYC)) u_props (.MCLK(MCLK), .ARST_N(ARST_N),
	.START(START), .BUSY(BUSY), .DONE(DONE), .REFUSED(REFUSED), .PW_READY(PW_READY), .METHOD_PW(METHOD_PW),
	.OP(OP), .LOCK_WORD(LOCK_WORD));
`default_nettype wire

// *** test/pml_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pml_flash_model #(
	parameter int BUSY_CYC = 30,
	parameter int SET_CYC  = 200
) (
	input  wire logic        MCLK, ARST_N, CE_N, OE_N, WE_N,
	input  wire logic [23:0] ADDR,
	input  wire logic [15:0] DQ_O,
	output logic      [15:0] DQ_I,
	output logic             RDY
);
	logic [15:0] lw = 16'hfefe;
	logic [15:0] pw [0:3] = '{4{16'hffff}};
	logic [15:0] wd [0:15];
	logic [23:0] wa [0:15];
	logic [3:0]  n;
	logic [3:0]  seen_a;
	logic        we_q, ce_q, guard, fail, ok;
	int          cnt;
	wire  [15:0] st = {8'h00, cnt == 0, 2'h0, fail, 4'h0};
	// Ready pin and status; a released bus shows the inverse
	assign RDY  = cnt == 0;
	assign DQ_I = (!CE_N && !OE_N) ? st : ~st;
	// Exact match of all four words in any address order
	always @*
	begin
		seen_a = 4'h0;
		ok = !lw[2] && wd[9] == 16'h0029;
		for (int k = 5; k < 9; k++)
		begin
			seen_a = seen_a | (4'h1 << wa[k][1:0]);
			ok = ok && wa[k][23:2] == 22'h0 && wd[k] == pw[wa[k][1:0]];
		end
		// Every one of the four word addresses must appear once
		ok = ok && seen_a == 4'hf;
	end
	// Capture writes, decode each command of more than four writes when chip select rises while ready
	always @(posedge MCLK or negedge ARST_N)
		if (!ARST_N)
		begin
			n     <= 4'h0;
			cnt   <= 0;
			fail  <= 1'h0;
			guard <= lw[2];
			we_q  <= 1'h1;
			ce_q  <= 1'h1;
		end
		else
		begin
			we_q <= WE_N;
			ce_q <= CE_N;
			if (cnt != 0)
				cnt <= cnt - 1;
			if (WE_N && !we_q && !CE_N)
			begin
				wa[n] <= ADDR;
				wd[n] <= DQ_O;
				n     <= n + 4'h1;
			end
			if (CE_N && !ce_q)
				n <= 4'h0;
			if (CE_N && !ce_q && n > 4'h4 && cnt == 0)
			begin
				fail <= 1'h0;
				cnt  <= BUSY_CYC;
				if (wd[2] == 16'h0040 && (!wd[4][1] && (!wd[4][2] || !lw[2]) || !wd[4][2] && !lw[1]))
					fail <= 1'h1;
				else if (wd[2] == 16'h0040)
					lw <= lw & (wd[4] | 16'hffb8);
				else if (wd[3] == 16'h00a0 && wd[2] == 16'h0060 && lw[2])
					pw[wa[4][1:0]] <= pw[wa[4][1:0]] & wd[4];
				else if (wd[3] == 16'h0025 && ok)
				begin
					guard <= 1'h1;
					cnt   <= SET_CYC;
				end
				else if (wd[3] == 16'h0025)
					fail <= 1'h1;
				else if (wd[2] == 16'h0050)
					guard <= 1'h0;
			end
		end
endmodule
`default_nettype wire

// *** test/pml_host_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module pml_host_test;
	typedef struct packed {logic [2:0] op; logic [15:0] lw; logic [1:0] ix; logic bad, rf, fl, gd;} pml_row_t;
	localparam logic [63:0] PW = 64'h0123456789abcdef;
	logic        MCLK, ARST_N, START, BUSY, DONE, FAIL, REFUSED, PW_READY, METHOD_PW, METHOD_PS;
	logic        CE_N, OE_N, WE_N, DQ_OE_N, RDY;
	logic [2:0]  OP;
	logic [1:0]  PW_INDEX;
	logic [15:0] LOCK_WORD, STATUS, DQ_O, DQ_I;
	logic [23:0] ADDR;
	logic [63:0] PASSWORD;
	int          n_errors = 0, num_checks = 0, cyc = 0;
	pml_row_t    rows [0:17] = '{{3'h0, 16'hffbf, 2'h0, 4'h1}, {3'h3, 16'hffff, 2'h0, 4'h0},
		{3'h0, 16'hfff9, 2'h0, 4'h4}, {3'h0, 16'hfffb, 2'h0, 4'h4}, {3'h1, 16'hffff, 2'h0, 4'h0},
		{3'h1, 16'hffff, 2'h1, 4'h0}, {3'h1, 16'hffff, 2'h2, 4'h0}, {3'h1, 16'hffff, 2'h3, 4'h0},
		{3'h0, 16'hfffb, 2'h0, 4'h0}, {3'h1, 16'hffff, 2'h0, 4'h4}, {3'h0, 16'hfffd, 2'h0, 4'h4},
		{3'h2, 16'hffff, 2'h0, 4'ha}, {3'h2, 16'hffff, 2'h0, 4'h4}, {3'h2, 16'hffff, 2'h0, 4'h1},
		{3'h3, 16'hffff, 2'h0, 4'h0}, {3'h2, 16'hffff, 2'h0, 4'h1}, {3'h5, 16'hffff, 2'h0, 4'h5},
		{3'h4, 16'hffff, 2'h0, 4'h1}};
	pml_host #(.GAP_CYC(14'h14), .TMO_CYC(20'h7d0)) u_dut (.MCLK(MCLK), .ARST_N(ARST_N), .START(START), .OP(OP),
		.LOCK_WORD(LOCK_WORD), .PASSWORD(PASSWORD), .PW_INDEX(PW_INDEX), .BUSY(BUSY), .DONE(DONE), .FAIL(FAIL),
		.REFUSED(REFUSED), .STATUS(STATUS), .PW_READY(PW_READY), .METHOD_PW(METHOD_PW), .METHOD_PS(METHOD_PS),
		.ADDR(ADDR), .DQ_O(DQ_O), .DQ_OE_N(DQ_OE_N), .DQ_I(DQ_I), .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N), .RDY(RDY));
	pml_flash_model u_flash (.MCLK(MCLK), .ARST_N(ARST_N), .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N), .ADDR(ADDR),
		.DQ_O(DQ_O), .DQ_I(DQ_I), .RDY(RDY));
	// Clock and hang guard
	initial
	begin
		MCLK = 1'h0;
		forever #5 MCLK = ~MCLK;
	end
	always @(posedge MCLK)
		if (++cyc == 20000)
		begin
			n_errors++;
			tally_and_finish();
		end
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One order, waited on until it finishes or is refused
	task automatic order(input pml_row_t r);
		@(negedge MCLK);
		OP = r.op;
		LOCK_WORD = r.lw;
		PW_INDEX = r.ix;
		PASSWORD = r.bad ? ~PW : PW;
		START = 1'h1;
		@(negedge MCLK);
		START = 1'h0;
		for (int k = 0; k < 3000 && DONE !== 1'h1 && REFUSED !== 1'h1; k++)
			@(negedge MCLK);
		chk("finished", DONE | REFUSED, 1'h1);
		chk("refused", REFUSED, r.rf);
		if (!r.rf)
			chk("fail", FAIL, r.fl);
		if (!r.rf)
			chk("status", STATUS & 16'h0090, r.fl ? 16'h0090 : 16'h0080);
		chk("guard", u_flash.guard, r.gd);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Reset, table of orders, then reset in mid-order
	initial
	begin
		{ARST_N, START, OP, LOCK_WORD, PASSWORD, PW_INDEX} = '0;
		repeat (8) @(negedge MCLK);
		ARST_N = 1'h1;
		for (int i = 0; i < 18; i++)
		begin
			if (rows[i].op == 3'h2 && !rows[i].rf)
				repeat (30) @(negedge MCLK);
			order(rows[i]);
		end
		chk("lock word", u_flash.lw, 16'hfeba);
		chk("methods", {METHOD_PW, METHOD_PS}, 2'h2);
		chk("password ready", PW_READY, 1'h1);
		OP = 3'h4;
		START = 1'h1;
		@(negedge MCLK);
		START = 1'h0;
		repeat (9) @(negedge MCLK);
		ARST_N = 1'h0;
		@(negedge MCLK);
		chk("reset outputs", {CE_N, WE_N, DQ_OE_N, BUSY, METHOD_PW}, 5'h1c);
		chk("ready after reset", PW_READY, 1'h0);
		ARST_N = 1'h1;
		chk("guard after reset", u_flash.guard, 1'h0);
		order({3'h1, 16'hffff, 2'h0, 4'h8});
		chk("password kept", u_flash.pw[0], PW[15:0]);
		tally_and_finish();
	end
endmodule
`default_nettype wire
